/* include/e1_status_defines.vh */
`ifndef E1_STATUS_DEFINES_VH
`define E1_STATUS_DEFINES_VH

// ----------
// Register offsets on the host control port
// ----------
`define OFS_PIN_IO_CONFIGURATION          8'h01
`define OFS_DEVICE_IDENTIFICATION         8'h10
`define OFS_RESYNC_EVENT_INFO             8'h12
`define OFS_RECEIVE_ALARM_STATUS          8'h16
`define OFS_RECEIVE_ALARM_INTERRUPT_MASK  8'h17
`define OFS_SYNC_SEARCH_REALTIME_INFO     8'h1C

// ----------
// Reset values
// ----------
`define RST_PIN_IO_CONFIGURATION          8'h00
`define RST_RECEIVE_ALARM_INTERRUPT_MASK  8'h00

// ----------
// Field positions
// ----------
`define BIT_OUTPUT_FORMAT      0
`define BIT_TX_SYNC_DIR        1
`define BIT_TX_SYNC_MF         2
`define BIT_TX_SYNC_DW         3
`define BIT_LOF_PIN_FUNC       4
`define BIT_RX_SYNC_SEL1       5
`define BIT_RX_SYNC_SEL2       6
`define IOCR_WRITE_MASK        8'h7F

// ----------
// Alarm criteria counts
// ----------
`define LOS_ZEROS_E1_SHORT     12'd255
`define LOS_ZEROS_E1_LONG      12'd2048
`define LOS_ZEROS_T1           12'd192
`define LOS_CLEAR_WINDOW       8'd255
`define LOS_CLEAR_ONES         8'd32
`define AIS_WINDOW_BITS        10'd512
`define AIS_ZERO_LIMIT         10'd3
`define FAS_ERR_RESYNC         2'd3
`define CAS_ERR_RESYNC         2'd2
`define CRC_BLOCK_WORDS        10'd1000
`define CRC_ERR_RESYNC         10'd915

`endif

/* src/e1_status_regs.v */
// How it works
// - Two bad CAS alignment words flag event
// - Three bad frame alignment words flag event
// - 915 of 1000 bad CRC4 words flag event
// - Search-active flags follow live search level
// - Search counter counts timeouts, clears, wraps
// - Six-bit counter, bit one hidden on read
// - Frame loss from reset, resync, manual request
// - Signal loss on zeros, cleared by ones
// - Remote alarm on three equal bit-3 samples
// - All-ones alarm from zeros per 512 bits
// - Distant multiframe alarm, two consecutive bits
// - Link indication when two Sa7 zeros
// - Read-only identification code and revision
// - T1 192 zeros; 6312kHz range fault
// - Frame-loss clear latched until read
// - AIS on all-ones; yellow only in T1
// - Mask gates sources; conditions on rising edge
// - Bipolar or NRZ transmit line format
// - Transmit sync pin direction and mode
// - Double-wide T1 transmit sync in signalling frames
// - Frame-loss pin shows frame or clock loss
// - Receive sync pin pulse selection
`timescale 1ns/100ps
`default_nettype none
`include "e1_status_defines.vh"

module e1_status_regs #(
  parameter [3:0] DEVICE_CODE   = 4'h5, // Arbitrary value
  parameter [3:0] REVISION_CODE = 4'h0  // Arbitrary value
) (
  // Clock and reset
  input  wire       mclk,
  input  wire       reset,
  // Host control port
  input  wire [7:0] host_addr,
  input  wire [7:0] host_wdata,
  input  wire       host_wr,
  input  wire       host_rd,
  output reg  [7:0] host_rdata,
  output wire       alarm_irq,
  // Receive configuration
  input  wire       mode_t1,
  input  wire       mode_6312,
  input  wire       crc4_enable,
  input  wire       los_long_select,
  input  wire       auto_resync_disable,
  input  wire       manual_resync,
  // Receive framer events
  input  wire       fas_word_strobe,
  input  wire       fas_word_error,
  input  wire       fas_sync_found,
  input  wire       cas_word_strobe,
  input  wire       cas_word_error,
  input  wire       cas_sync_found,
  input  wire       crc_word_strobe,
  input  wire       crc_word_error,
  input  wire       crc_sync_found,
  input  wire       crc_search_timeout,
  input  wire       nfas_strobe,
  input  wire       nfas_bit3,
  input  wire       nfas_sa7,
  input  wire       mf_ts16_strobe,
  input  wire       mf_ts16_bit6,
  input  wire       rx_bit_strobe,
  input  wire       rx_bit,
  input  wire       range_fault_6312,
  input  wire       t1_yellow_detect,
  // Status outputs
  output reg        rx_remote_alarm,
  output reg        rx_unframed_ones,
  output reg        rx_distant_mf_alarm,
  output wire       access_link_indication,
  // Transmit line
  input  wire       tx_bipolar_pos,
  input  wire       tx_bipolar_neg,
  input  wire       tx_nrz_data,
  output reg        tx_line_positive,
  output reg        tx_line_negative,
  // Transmit sync pin
  input  wire       tx_frame_pulse,
  input  wire       tx_mf_pulse,
  input  wire       tx_sig_frame,
  input  wire       tx_sync_pin_in,
  output reg        tx_sync_pin_out,
  output wire       tx_sync_pin_oe,
  output wire       tx_sync_to_formatter,
  // Frame-loss pin
  input  wire       tx_clock_loss,
  output reg        rx_frame_loss_pin,
  // Receive sync pin
  input  wire       rx_frame_pulse,
  input  wire       rx_mf_pulse,
  input  wire       rx_cas_mf_pulse,
  input  wire       rx_crc_mf_pulse,
  input  wire       rx_sig_frame,
  output reg        rx_sync_pin
);

  // ----------
  // Register storage
  // ----------
  reg  [7:0]  pin_io_configuration;
  reg  [7:0]  receive_alarm_interrupt_mask;
  reg         cas_resync_event, frame_align_resync_event, crc_resync_event;
  reg         rx_frame_loss, rx_signal_loss;
  reg         rx_frame_loss_cleared, rx_signal_loss_cleared;
  reg         rx_alarm_indication_cleared, rx_yellow_alarm_cleared;
  reg  [3:0]  cond_pending;
  reg         cas_mf_search_active, crc_mf_search_active;
  reg  [5:0]  crc_search_count;
  wire wr_iocr = host_wr && (host_addr == `OFS_PIN_IO_CONFIGURATION);
  wire wr_imr  = host_wr && (host_addr == `OFS_RECEIVE_ALARM_INTERRUPT_MASK);
  wire rd_info = host_rd && (host_addr == `OFS_RESYNC_EVENT_INFO);
  wire rd_sr   = host_rd && (host_addr == `OFS_RECEIVE_ALARM_STATUS);

  wire frame_align_search_active = rx_frame_loss;
  wire rx_alarm_indication       = rx_unframed_ones;
  wire rx_yellow_alarm           = mode_t1 & t1_yellow_detect;

  // ----------
  // Resync criteria
  // ----------
  reg  [1:0]  fas_err_run, cas_err_run;
  reg  [9:0]  crc_word_cnt, crc_err_cnt;
  reg         manual_resync_d;
  wire fas_hit = fas_word_strobe && fas_word_error &&
                 (fas_err_run == `FAS_ERR_RESYNC - 2'd1);
  wire cas_hit = cas_word_strobe && cas_word_error &&
                 (cas_err_run == `CAS_ERR_RESYNC - 2'd1);
  wire [9:0] crc_err_next = crc_err_cnt + {9'd0, crc_word_error};
  wire crc_end = crc_word_strobe && (crc_word_cnt == `CRC_BLOCK_WORDS - 10'd1);
  wire crc_hit = crc_end && (crc_err_next >= `CRC_ERR_RESYNC);
  wire manual_rise = manual_resync & ~manual_resync_d;

  // Consecutive error runs and the 1000-word CRC block
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      fas_err_run     <= 2'd0;
      cas_err_run     <= 2'd0;
      crc_word_cnt    <= 10'd0;
      crc_err_cnt     <= 10'd0;
      manual_resync_d <= 1'b0;
    end else begin
      manual_resync_d <= manual_resync;
      if (fas_word_strobe) begin
        if (!fas_word_error || fas_hit)
          fas_err_run <= 2'd0;
        else
          fas_err_run <= fas_err_run + 2'd1;
      end
      if (cas_word_strobe) begin
        if (!cas_word_error || cas_hit)
          cas_err_run <= 2'd0;
        else
          cas_err_run <= cas_err_run + 2'd1;
      end
      if (crc_word_strobe) begin
        if (crc_end) begin
          crc_word_cnt <= 10'd0;
          crc_err_cnt  <= 10'd0;
        end else begin
          crc_word_cnt <= crc_word_cnt + 10'd1;
          crc_err_cnt  <= crc_err_next;
        end
      end
    end
  end

  // Event flags; a new event beats the read that clears it
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cas_resync_event         <= 1'b0;
      frame_align_resync_event <= 1'b0;
      crc_resync_event         <= 1'b0;
    end else begin
      cas_resync_event         <= cas_hit | (cas_resync_event & ~rd_info);
      frame_align_resync_event <= fas_hit | (frame_align_resync_event & ~rd_info);
      crc_resync_event         <= crc_hit | (crc_resync_event & ~rd_info);
    end
  end

  // ----------
  // Synchronizer state and search counter
  // ----------
  // Auto resync only acts when not disabled; manual always acts
  wire resync_go = manual_rise |
                   (~auto_resync_disable & (fas_hit | cas_hit | crc_hit));

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_frame_loss        <= 1'b1;
      cas_mf_search_active <= 1'b0;
      crc_mf_search_active <= 1'b0;
      crc_search_count     <= 6'd0;
    end else begin
      if (resync_go)
        rx_frame_loss <= 1'b1;
      else if (fas_sync_found)
        rx_frame_loss <= 1'b0;
      if (resync_go)
        cas_mf_search_active <= 1'b0;
      else if (fas_sync_found && rx_frame_loss)
        cas_mf_search_active <= 1'b1;
      else if (cas_sync_found)
        cas_mf_search_active <= 1'b0;
      if (resync_go || !crc4_enable)
        crc_mf_search_active <= 1'b0;
      else if (fas_sync_found && rx_frame_loss)
        crc_mf_search_active <= 1'b1;
      else if (crc_sync_found)
        crc_mf_search_active <= 1'b0;
      if (crc_sync_found || !crc4_enable)
        crc_search_count <= 6'd0;
      else if (crc_search_timeout)
        crc_search_count <= crc_search_count + 6'd1; // wraps
    end
  end

  // ----------
  // Loss of signal
  // ----------
  reg  [11:0] zero_run;
  reg  [7:0]  win_cnt, win_ones;
  wire [11:0] los_limit = mode_t1 ? `LOS_ZEROS_T1 :
                          (los_long_select ? `LOS_ZEROS_E1_LONG : `LOS_ZEROS_E1_SHORT);
  wire zero_hit = rx_bit_strobe && !rx_bit && (zero_run == los_limit - 12'd1);
  wire ones_hit = rx_bit_strobe && rx_bit && (win_ones == `LOS_CLEAR_ONES - 8'd1);
  // T1 clear rule is owned by the framer; here the same ones window is reused

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      zero_run       <= 12'd0;
      win_cnt        <= 8'd0;
      win_ones       <= 8'd0;
      rx_signal_loss <= 1'b0;
    end else begin
      if (rx_bit_strobe) begin
        if (rx_bit)
          zero_run <= 12'd0;
        else if (zero_run != los_limit)
          zero_run <= zero_run + 12'd1;
        // Window opens with the first one seen
        if (win_cnt == `LOS_CLEAR_WINDOW - 8'd1 || ones_hit) begin
          win_cnt  <= 8'd0;
          win_ones <= 8'd0;
        end else if (win_cnt != 8'd0 || rx_bit) begin
          win_cnt  <= win_cnt + 8'd1;
          win_ones <= win_ones + {7'd0, rx_bit};
        end
      end
      if (mode_6312)
        rx_signal_loss <= range_fault_6312;
      else if (zero_hit)
        rx_signal_loss <= 1'b1;
      else if (ones_hit)
        rx_signal_loss <= 1'b0;
    end
  end

  // ----------
  // All-ones, remote, distant MF, Sa7 alarms
  // ----------
  reg  [9:0] ais_bits, ais_zeros;
  reg  [2:0] bit3_hist, sa7_hist;
  reg        bit6_prev;
  wire [9:0] ais_zeros_next = ais_zeros + {9'd0, ~rx_bit};

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      ais_bits            <= 10'd0;
      ais_zeros           <= 10'd0;
      rx_unframed_ones    <= 1'b0;
      bit3_hist           <= 3'b000;
      rx_remote_alarm     <= 1'b0;
      sa7_hist            <= 3'b111;
      bit6_prev           <= 1'b0;
      rx_distant_mf_alarm <= 1'b0;
    end else begin
      if (rx_bit_strobe) begin
        if (ais_bits == `AIS_WINDOW_BITS - 10'd1) begin
          ais_bits         <= 10'd0;
          ais_zeros        <= 10'd0;
          rx_unframed_ones <= (ais_zeros_next < `AIS_ZERO_LIMIT);
        end else begin
          ais_bits  <= ais_bits + 10'd1;
          ais_zeros <= ais_zeros_next;
        end
      end
      if (nfas_strobe) begin
        bit3_hist <= {bit3_hist[1:0], nfas_bit3};
        sa7_hist  <= {sa7_hist[1:0], nfas_sa7};
        if (bit3_hist[1:0] == 2'b11 && nfas_bit3)
          rx_remote_alarm <= 1'b1;
        else if (bit3_hist[1:0] == 2'b00 && !nfas_bit3)
          rx_remote_alarm <= 1'b0;
      end
      if (mf_ts16_strobe) begin
        bit6_prev           <= mf_ts16_bit6;
        rx_distant_mf_alarm <= bit6_prev & mf_ts16_bit6;
      end
    end
  end

  // At least two of the last three Sa7 bits are zero
  assign access_link_indication = (~sa7_hist[0] & ~sa7_hist[1]) |
                                  (~sa7_hist[0] & ~sa7_hist[2]) |
                                  (~sa7_hist[1] & ~sa7_hist[2]);

  // ----------
  // Status clear events and interrupt
  // ----------
  reg  [3:0] cond_d;
  wire [3:0] cond_now = {rx_yellow_alarm, rx_alarm_indication,
                         rx_signal_loss, rx_frame_loss};
  wire [3:0] cond_rise = cond_now & ~cond_d;
  wire [3:0] cond_fall = ~cond_now & cond_d;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cond_d                      <= 4'b0001;
      cond_pending                <= 4'b0000;
      rx_frame_loss_cleared       <= 1'b0;
      rx_signal_loss_cleared      <= 1'b0;
      rx_alarm_indication_cleared <= 1'b0;
      rx_yellow_alarm_cleared     <= 1'b0;
    end else begin
      cond_d       <= cond_now;
      cond_pending <= cond_rise | (cond_pending & {4{~rd_sr}});
      rx_frame_loss_cleared <= cond_fall[0] |
                               (rx_frame_loss_cleared & ~rd_sr);
      rx_signal_loss_cleared <= cond_fall[1] |
                                (rx_signal_loss_cleared & ~rd_sr);
      rx_alarm_indication_cleared <= cond_fall[2] |
                                     (rx_alarm_indication_cleared & ~rd_sr);
      rx_yellow_alarm_cleared <= cond_fall[3] |
                                 (rx_yellow_alarm_cleared & ~rd_sr);
    end
  end

  wire [7:0] irq_src = {rx_yellow_alarm_cleared, rx_alarm_indication_cleared,
                        rx_signal_loss_cleared, rx_frame_loss_cleared, cond_pending};
  assign alarm_irq = |(irq_src & receive_alarm_interrupt_mask);

  // ----------
  // Register writes and reads
  // ----------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_io_configuration         <= `RST_PIN_IO_CONFIGURATION;
      receive_alarm_interrupt_mask <= `RST_RECEIVE_ALARM_INTERRUPT_MASK;
      host_rdata                   <= 8'h00;
    end else begin
      if (wr_iocr)
        pin_io_configuration <= host_wdata & `IOCR_WRITE_MASK;
      if (wr_imr)
        receive_alarm_interrupt_mask <= host_wdata;
      if (host_rd) begin
        if (host_addr == `OFS_PIN_IO_CONFIGURATION)
          host_rdata <= pin_io_configuration;
        else if (host_addr == `OFS_DEVICE_IDENTIFICATION)
          host_rdata <= {DEVICE_CODE, REVISION_CODE};
        else if (host_addr == `OFS_RESYNC_EVENT_INFO)
          host_rdata <= {5'd0, crc_resync_event, frame_align_resync_event,
                         cas_resync_event};
        else if (host_addr == `OFS_RECEIVE_ALARM_STATUS)
          host_rdata <= {rx_yellow_alarm_cleared, rx_alarm_indication_cleared,
                         rx_signal_loss_cleared, rx_frame_loss_cleared, cond_now};
        else if (host_addr == `OFS_RECEIVE_ALARM_INTERRUPT_MASK)
          host_rdata <= receive_alarm_interrupt_mask;
        else if (host_addr == `OFS_SYNC_SEARCH_REALTIME_INFO)
          host_rdata <= {crc_search_count[5:2], crc_search_count[0],
                         frame_align_search_active, cas_mf_search_active,
                         crc_mf_search_active};
        else
          host_rdata <= 8'h00;
      end
    end
  end

  // ----------
  // Pin configuration
  // ----------
  wire cfg_nrz  = pin_io_configuration[`BIT_OUTPUT_FORMAT];
  wire cfg_tdir = pin_io_configuration[`BIT_TX_SYNC_DIR];
  wire cfg_tmf  = pin_io_configuration[`BIT_TX_SYNC_MF];
  wire cfg_tdw  = pin_io_configuration[`BIT_TX_SYNC_DW];
  wire cfg_lofp = pin_io_configuration[`BIT_LOF_PIN_FUNC];
  wire cfg_rs1  = pin_io_configuration[`BIT_RX_SYNC_SEL1];
  wire cfg_rs2  = pin_io_configuration[`BIT_RX_SYNC_SEL2];

  // Sync pin input is asynchronous to mclk
  reg ts_meta, ts_sync, tx_stretch;

  wire tx_pulse    = cfg_tmf ? tx_mf_pulse : tx_frame_pulse;
  wire rx_base     = cfg_rs1 ? (mode_t1 ? rx_mf_pulse :
                                (cfg_rs2 ? rx_crc_mf_pulse : rx_cas_mf_pulse))
                             : rx_frame_pulse;
  wire rx_dw_on    = mode_t1 & ~cfg_rs1 & cfg_rs2 & rx_sig_frame;
  reg  rx_stretch;

  assign tx_sync_pin_oe       = cfg_tdir;
  assign tx_sync_to_formatter = ts_sync & ~cfg_tdir;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      ts_meta           <= 1'b0;
      ts_sync           <= 1'b0;
      tx_stretch        <= 1'b0;
      rx_stretch        <= 1'b0;
      tx_sync_pin_out   <= 1'b0;
      rx_sync_pin       <= 1'b0;
      tx_line_positive  <= 1'b0;
      tx_line_negative  <= 1'b0;
      rx_frame_loss_pin <= 1'b1;
    end else begin
      ts_meta    <= tx_sync_pin_in;
      ts_sync    <= ts_meta;
      // Second clock of a double-wide pulse
      tx_stretch <= tx_pulse & mode_t1 & cfg_tdir & cfg_tdw & tx_sig_frame;
      tx_sync_pin_out <= cfg_tdir & (tx_pulse | tx_stretch);
      rx_stretch  <= rx_base & rx_dw_on;
      rx_sync_pin <= rx_base | rx_stretch;
      tx_line_positive <= cfg_nrz ? tx_nrz_data : tx_bipolar_pos;
      tx_line_negative <= cfg_nrz ? 1'b0 : tx_bipolar_neg;
      rx_frame_loss_pin <= cfg_lofp ? tx_clock_loss : rx_frame_loss;
    end
  end

endmodule
`default_nettype wire

/* test/e1_status_props.sv */
`timescale 1ns/100ps
`default_nettype none
module e1_status_props #(
  parameter [3:0] DEVICE_CODE   = 4'h5,
  parameter [3:0] REVISION_CODE = 4'h0
) (
  // Clock, reset, host port
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic       host_wr,
  input wire logic       host_rd,
  input wire logic [7:0] host_rdata,
  input wire logic       alarm_irq,
  // Framer side
  input wire logic       auto_resync_disable,
  input wire logic       fas_word_strobe,
  input wire logic       fas_word_error,
  input wire logic       nfas_strobe,
  input wire logic       nfas_bit3,
  input wire logic       rx_remote_alarm,
  // Pins
  input wire logic       tx_bipolar_pos,
  input wire logic       tx_line_positive,
  input wire logic       tx_line_negative,
  input wire logic       tx_sync_pin_oe,
  input wire logic       tx_clock_loss,
  input wire logic       rx_frame_loss_pin
);
  // ----------
  // Shadow state
  // ----------
  reg [7:0] iocr;
  reg [7:0] imr;
  reg [1:0] fe_cnt;
  reg [1:0] ra_one;
  reg [1:0] ra_zero;
  // Shadows rebuilt from host writes and framer strobes
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      {iocr, imr, fe_cnt, ra_one, ra_zero} <= 22'd0;
    end else begin
      if (host_wr && host_addr == 8'h01) iocr <= host_wdata & 8'h7F;
      if (host_wr && host_addr == 8'h17) imr <= host_wdata;
      // Saturate at two: the next errored word is a third or later one
      if (fas_word_strobe) fe_cnt <= !fas_word_error ? 2'd0 : fe_cnt + {1'b0, fe_cnt != 2'd2};
      if (nfas_strobe) ra_one <= !nfas_bit3 ? 2'd0 : ra_one + {1'b0, ra_one != 2'd3};
      if (nfas_strobe) ra_zero <= nfas_bit3 ? 2'd0 : ra_zero + {1'b0, ra_zero != 2'd3};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ----------
  // Properties
  // ----------
  a_unmapped_read_zero: assert property (host_rd && host_addr == 8'h20 |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ident_code_value: assert property (host_rd && host_addr == 8'h10 |=>
    host_rdata == {DEVICE_CODE, REVISION_CODE}) else $error("identification mismatch");
  a_irq_all_masked: assert property (imr == 8'h00 |-> !alarm_irq)
    else $error("interrupt with all sources masked");
  a_nrz_neg_low: assert property (iocr[0] |=> !tx_line_negative)
    else $error("negative line driven in NRZ format");
  a_bipolar_passes: assert property (!iocr[0] |=> tx_line_positive == $past(tx_bipolar_pos))
    else $error("bipolar positive line wrong");
  a_sync_oe_dir: assert property (tx_sync_pin_oe == iocr[1])
    else $error("sync pin enable differs from direction");
  a_lof_pin_clock: assert property (iocr[4] |=> rx_frame_loss_pin == $past(tx_clock_loss))
    else $error("frame-loss pin not showing clock loss");
  a_fas_resync_lof: assert property (fas_word_strobe && fas_word_error && fe_cnt == 2'd2 &&
    !auto_resync_disable && !iocr[4] |=> ##1 rx_frame_loss_pin) else $error("no frame loss");
  a_remote_set_three: assert property (ra_one == 2'd3 |-> rx_remote_alarm)
    else $error("remote alarm not set");
  a_remote_clear_three: assert property (ra_zero == 2'd3 |-> !rx_remote_alarm)
    else $error("remote alarm not cleared");
  c_ident_read: cover property (host_rd && host_addr == 8'h10);
  c_remote_rise: cover property ($rose(rx_remote_alarm));
  c_irq_rise: cover property ($rose(alarm_irq));
endmodule
bind e1_status_regs e1_status_props #(
  .DEVICE_CODE   (DEVICE_CODE),
  .REVISION_CODE (REVISION_CODE)
) i_e1_status_props (.*);
`default_nettype wire

/* test/line_bit_source.sv */
`timescale 1ns/100ps
`default_nettype none
module line_bit_source (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control from the bench
  input wire logic run,
  input wire logic level,
  // Received line bits
  output logic     rx_bit_strobe,
  output logic     rx_bit
);
  // One bit every second clock; off-strobe the data shows its inverse so it never looks valid
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_bit_strobe <= 1'b0;
      rx_bit <= 1'b0;
    end else if (run && !rx_bit_strobe) begin
      rx_bit_strobe <= 1'b1;
      rx_bit <= level;
    end else begin
      rx_bit_strobe <= 1'b0;
      rx_bit <= ~rx_bit;
    end
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk, reset, host_wr, host_rd, run, level;
  logic [7:0] host_addr, host_wdata;
  logic [8:0] stb;
  logic mode_t1, crc4_enable, los_long_select, auto_resync_disable, manual_resync;
  logic fas_word_error, cas_word_error, crc_word_error, nfas_bit3, nfas_sa7, mf_ts16_bit6;
  logic tx_bipolar_pos, tx_bipolar_neg, tx_nrz_data, tx_frame_pulse, tx_mf_pulse;
  logic tx_sync_pin_in, tx_clock_loss, rx_frame_pulse, rx_mf_pulse;
  logic rx_cas_mf_pulse, rx_crc_mf_pulse;
  wire [7:0] host_rdata;
  wire alarm_irq, rx_remote_alarm, rx_unframed_ones, rx_distant_mf_alarm;
  wire access_link_indication, tx_line_positive, tx_line_negative, tx_sync_pin_out;
  wire tx_sync_pin_oe, tx_sync_to_formatter, rx_frame_loss_pin, rx_sync_pin;
  wire rx_bit_strobe, rx_bit;
  wire fas_word_strobe, cas_word_strobe, crc_word_strobe, fas_sync_found, cas_sync_found;
  wire crc_sync_found, crc_search_timeout, nfas_strobe, mf_ts16_strobe;
  // Tied off: 6312kHz and T1 signalling paths are out of scope here
  wire mode_6312 = 1'b0;
  wire range_fault_6312 = 1'b0;
  wire t1_yellow_detect = 1'b0;
  wire tx_sig_frame = 1'b0;
  wire rx_sig_frame = 1'b0;
  int mismatches = 0;
  int num_checks = 0;
  // One-cycle framer strobes share a vector so one task pulses any of them
  assign {fas_word_strobe, cas_word_strobe, crc_word_strobe, fas_sync_found, cas_sync_found,
          crc_sync_found, crc_search_timeout, nfas_strobe, mf_ts16_strobe} = stb;
  // Identification codes below are arbitrary
  e1_status_regs #(.DEVICE_CODE(4'hA), .REVISION_CODE(4'h3)) i_e1_status_regs (.*);
  line_bit_source i_line_bit_source (.*);
  always #12.5 mclk = ~mclk;
  // ----------
  // Helpers
  // ----------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge mclk);
    host_wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge mclk);
    host_rd = 1'b0;
    chk(host_rdata, exp);
    @(negedge mclk);
  endtask
  task automatic pulse(input int i);
    stb[i] = 1'b1;
    @(negedge mclk);
    stb = '0;
    @(negedge mclk);
  endtask
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    rd(8'h01, 8'h00);
    rd(8'h17, 8'h00);
    rd(8'h12, 8'h00);
    rd(8'h1C, 8'h04);
    rd(8'h16, 8'h01);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'hA3);
    rd(8'h20, 8'h00);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h7F);
    wr(8'h01, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_sync;
    pulse(5);
    rd(8'h16, 8'h10);
    rd(8'h16, 8'h00);
    rd(8'h1C, 8'h03);
    repeat (3) pulse(2);
    rd(8'h1C, 8'h0B);
    repeat (2) pulse(2);
    rd(8'h1C, 8'h1B);
    repeat (59) pulse(2);
    rd(8'h1C, 8'h03);
    pulse(3);
    rd(8'h1C, 8'h02);
    $display("test sync done");
  endtask
  task automatic t_resync;
    repeat (86) pulse(6);
    crc_word_error = 1'b1;
    repeat (914) pulse(6);
    rd(8'h12, 8'h00);
    crc_word_error = 1'b0;
    repeat (85) pulse(6);
    crc_word_error = 1'b1;
    repeat (915) pulse(6);
    cas_word_error = 1'b1;
    repeat (2) pulse(7);
    fas_word_error = 1'b1;
    repeat (3) pulse(8);
    rd(8'h12, 8'h07);
    rd(8'h12, 8'h00);
    rd(8'h16, 8'h01);
    {crc_word_error, cas_word_error, fas_word_error} = 3'b000;
    $display("test resync done");
  endtask
  task automatic t_manual;
    pulse(5);
    rd(8'h16, 8'h10);
    manual_resync = 1'b1;
    repeat (2) @(negedge mclk);
    rd(8'h16, 8'h01);
    chk({7'h00, rx_frame_loss_pin}, 8'h01);
    manual_resync = 1'b0;
    $display("test manual done");
  endtask
  task automatic t_alarms;
    nfas_bit3 = 1'b1;
    repeat (3) pulse(1);
    chk({7'h00, rx_remote_alarm}, 8'h01);
    nfas_bit3 = 1'b0;
    nfas_sa7 = 1'b0;
    repeat (2) pulse(1);
    chk({6'h00, rx_remote_alarm, access_link_indication}, 8'h03);
    pulse(1);
    chk({7'h00, rx_remote_alarm}, 8'h00);
    mf_ts16_bit6 = 1'b1;
    pulse(0);
    chk({7'h00, rx_distant_mf_alarm}, 8'h00);
    pulse(0);
    chk({7'h00, rx_distant_mf_alarm}, 8'h01);
    $display("test alarms done");
  endtask
  task automatic t_los_irq;
    wr(8'h17, 8'h22);
    run = 1'b1;
    repeat (500) @(negedge mclk);
    chk({7'h00, alarm_irq}, 8'h00);
    repeat (20) @(negedge mclk);
    chk({7'h00, alarm_irq}, 8'h01);
    rd(8'h16, 8'h03);
    chk({7'h00, alarm_irq}, 8'h00);
    level = 1'b1;
    repeat (56) @(negedge mclk);
    rd(8'h16, 8'h03);
    repeat (10) @(negedge mclk);
    chk({7'h00, alarm_irq}, 8'h01);
    rd(8'h16, 8'h21);
    repeat (2100) @(negedge mclk);
    chk({6'h00, rx_unframed_ones, alarm_irq}, 8'h02);
    rd(8'h16, 8'h05);
    level = 1'b0;
    repeat (1100) @(negedge mclk);
    rd(8'h16, 8'h43);
    run = 1'b0;
    $display("test los done");
  endtask
  task automatic t_pins;
    {tx_bipolar_pos, tx_bipolar_neg, tx_sync_pin_in} = 3'b111;
    repeat (3) @(negedge mclk);
    chk({4'h0, tx_line_positive, tx_line_negative, tx_sync_pin_oe, tx_sync_to_formatter},
        8'h0D);
    wr(8'h01, 8'h13);
    {tx_nrz_data, tx_bipolar_pos, tx_clock_loss, tx_frame_pulse, rx_frame_pulse} = 5'b10111;
    @(negedge mclk);
    chk({1'b0, tx_line_positive, tx_line_negative, tx_sync_pin_oe, tx_sync_to_formatter,
        rx_frame_loss_pin, tx_sync_pin_out, rx_sync_pin}, 8'h57);
    {tx_frame_pulse, rx_frame_pulse} = 2'b00;
    $display("test pins done");
  endtask
  // ----------
  // Main sequence and watchdog
  // ----------
  initial begin
    {host_wr, host_rd, host_addr, host_wdata, stb, mode_t1, los_long_select, run, level,
     auto_resync_disable, manual_resync, fas_word_error, cas_word_error, crc_word_error,
     nfas_bit3, mf_ts16_bit6, tx_bipolar_pos, tx_bipolar_neg, tx_nrz_data, tx_frame_pulse,
     tx_mf_pulse, tx_sync_pin_in, tx_clock_loss, rx_frame_pulse, rx_mf_pulse,
     rx_cas_mf_pulse, rx_crc_mf_pulse} = '0;
    {mclk, reset, nfas_sa7, crc4_enable} = 4'b0111;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    t_reset;
    t_sync;
    t_resync;
    t_manual;
    t_alarms;
    t_los_irq;
    t_pins;
    conclude;
  end
  // Run needs about 8000 cycles; allow two and a half times that
  initial begin
    #500000;
    mismatches++;
    $display("watchdog expired");
    conclude;
  end
endmodule
`default_nettype wire
